/* bra_pkg.sv */
// Package for the bridge ADC register access front end.
// Holds command byte layout, register selectors, reset values and lengths.
// Assumes one 125 MHz clock and a serial port driven by an outside host.
package bra_pkg;

	// Command byte fields
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_LEN_BITS = 8;
	localparam logic [1:0] DIR_WRITE = 2'h0;
	localparam logic [1:0] DIR_READ = 2'h1;
	localparam logic [1:0] DIR_CONT_START = 2'h2;
	localparam logic [1:0] DIR_CONT_STOP = 2'h3;

	// Register selectors (thirteen registers share eight selector codes)
	localparam logic [2:0] SEL_COMMAND = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_DATA = 3'h2;
	localparam logic [2:0] SEL_MODE = 3'h3;
	localparam logic [2:0] SEL_DAC = 3'h5;

	// Reset values
	localparam logic [15:0] MODE_RESET = 16'h01B0;
	localparam logic [3:0] STATUS_RESET_HI = 4'hC;
	localparam logic [23:0] RESULT_RESET = 24'h000000;

	// Mode register fields
	localparam int MODE_WL_BIT = 8;
	localparam int MODE_CLOCK_OUT_DISABLE_BIT = 3;
	localparam int MODE_ECHO_LSB = 12;

	// Transfer lengths in bits
	localparam logic [4:0] LEN_CMD = 5'h08;
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_HALF = 5'h10;
	localparam logic [4:0] LEN_LONG = 5'h18;

	// Command byte as written by the host
	typedef struct packed {
		logic wen_n;
		logic zero_a;
		logic access_dir_hi;
		logic access_dir_lo;
		logic zero_b;
		logic target_sel_2;
		logic target_sel_1;
		logic target_sel_0;
	} bra_cmd_s;

	// Conversion engine report, same clock domain
	typedef struct packed {
		logic valid;
		logic [23:0] data;
		logic step_settled_flag;
		logic standby_flag;
		logic reference_missing_flag;
	} bra_adc_s;

	typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} bra_state_e;

	// Bits moved by one transfer to the selected register
	function automatic logic [4:0] bra_xfer_len(input logic [2:0] sel,
		input logic result_width_sel);
		logic [4:0] len;
		len = LEN_LONG;
		unique case (sel)
			SEL_COMMAND, SEL_STATUS, SEL_DAC: len = LEN_BYTE;
			SEL_DATA: len = result_width_sel ? LEN_LONG : LEN_HALF;
			SEL_MODE: len = LEN_HALF;
			default: len = LEN_LONG;
		endcase
		return len;
	endfunction

endpackage

/* bra_shift.sv */
// Output serialiser for the read path of the serial port.
// Assumes load and shift come from the same clock and never coincide.
`timescale 1ns/100ps
module bra_shift
	import bra_pkg::*;
#(
	parameter int W = 24
)
(
	input wire logic clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic load, // Take a new left-justified word
	input wire logic [W-1:0] load_val, // Word to send, MSB first
	input wire logic shift, // Advance one bit
	output logic sout // Current bit on the line
);

	logic [W-1:0] word_q; // Bits still to be sent

	// Load wins; shifting pulls zeros in behind the word
	always_ff @(posedge clk)
	begin
		if (!rstn)
			word_q <= '0;
		else if (load)
			word_q <= load_val;
		else if (shift)
			word_q <= {word_q[W-2:0], 1'b0};
	end

	assign sout = word_q[W-1];

endmodule

/* bra_regs.sv */
// Register access front end of a bridge ADC serial port.
// Assumes sclk, din and cs_n come from an outside host (asynchronous),
// and the conversion report comes from logic on clk.
`timescale 1ns/100ps
module bra_regs
	import bra_pkg::*;
(
	input wire logic clk, // System clock, 125 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic sclk, // Serial clock from host
	input wire logic din, // Serial data from host
	input wire logic cs_n, // Chip select from host, active low
	input wire bra_adc_s adc, // Conversion report
	output logic dout, // Serial data to host
	output logic [15:0] mode_q, // Mode register for analog side
	output logic clock_out_disable // Master clock output off
);

	// Pin synchronisers; the first stage feeds only the second
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic din_s1_q, din_s2_q;
	logic csn_s1_q, csn_s2_q;

	bra_state_e state_q; // Transfer state
	logic [4:0] cnt_q; // Bits done in this transfer
	logic [4:0] len_q; // Bits in this transfer
	logic [2:0] sel_q; // Target register
	logic cont_q; // Continuous read active
	logic [22:0] sh_in_q; // Bits received so far
	logic skip_q; // Hold first bit over the next fall
	logic pending_q; // Unread result waiting
	logic [23:0] result_q; // Newest conversion result
	logic settled_q, standby_q, refmiss_q; // Status flags

	logic rise, fall, cs_act, done;
	logic [23:0] word_in; // Full received word incl. current bit
	bra_cmd_s cmd; // Received byte seen as a command
	logic [2:0] next_sel;
	logic go_read;
	logic [7:0] status_byte;
	logic [23:0] rd_word;
	logic load;

	// Two flops on every pin, third only on sclk for edges
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			// Serial clock idles high; a low reset value would fake a rise
			sclk_s1_q <= 1'b1;
			sclk_s2_q <= 1'b1;
			sclk_s3_q <= 1'b1;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
			csn_s1_q <= 1'b1;
			csn_s2_q <= 1'b1;
		end
		else
		begin
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			din_s1_q <= din;
			din_s2_q <= din_s1_q;
			csn_s1_q <= cs_n;
			csn_s2_q <= csn_s1_q;
		end
	end

	assign cs_act = !csn_s2_q;
	assign rise = cs_act && sclk_s2_q && !sclk_s3_q;
	assign fall = cs_act && !sclk_s2_q && sclk_s3_q;
	assign done = rise && (cnt_q == len_q - 5'h01);
	assign word_in = {sh_in_q, din_s2_q};
	assign cmd = word_in[7:0];

	// Status byte: ready is low while a result waits
	assign status_byte = {!pending_q, settled_q, standby_q, refmiss_q,
		mode_q[MODE_ECHO_LSB+3:MODE_ECHO_LSB]};

	// Target of the word about to be sent
	assign next_sel = (state_q == ST_CMD) ?
		{cmd.target_sel_2, cmd.target_sel_1, cmd.target_sel_0} : sel_q;

	// Read words are left-justified; unmodelled registers read zero
	always_comb
	begin
		rd_word = 24'h000000;
		unique case (next_sel)
			SEL_STATUS: rd_word = {status_byte, 16'h0000};
			SEL_DATA: rd_word = mode_q[MODE_WL_BIT] ? result_q
				: {result_q[23:8], 8'h00};
			SEL_MODE: rd_word = {mode_q, 8'h00};
			default: rd_word = 24'h000000;
		endcase
	end

	// A read word is loaded when a read command or a continuous word completes, and while deselected in continuous mode
	assign go_read = (state_q == ST_CMD) && !cmd.wen_n
		&& ({cmd.access_dir_hi, cmd.access_dir_lo} == DIR_READ
		|| {cmd.access_dir_hi, cmd.access_dir_lo} == DIR_CONT_START);
	assign load = (!cs_act && cont_q)
		|| (done && (go_read || (state_q == ST_RD && cont_q
		&& word_in[7:0] != {2'b00, DIR_CONT_STOP, 1'b0, SEL_DATA})));

	// Incoming bits shift in on each rising serial edge
	always_ff @(posedge clk)
	begin
		if (!rstn)
			sh_in_q <= '0;
		else if (rise)
			sh_in_q <= word_in[22:0];
	end

	// Transfer sequencing: command, then one addressed transfer, or data words until the stop byte in continuous read
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_q <= ST_CMD;
			cnt_q <= 5'h00;
			len_q <= LEN_CMD;
			sel_q <= SEL_COMMAND;
			cont_q <= 1'b0;
		end
		else if (!cs_act)
		begin
			// Deselect aborts a word; continuous read resumes later
			cnt_q <= 5'h00;
			state_q <= cont_q ? ST_RD : ST_CMD;
			len_q <= cont_q ? bra_xfer_len(SEL_DATA, mode_q[MODE_WL_BIT])
				: LEN_CMD;
		end
		else if (done)
		begin
			cnt_q <= 5'h00;
			unique case (state_q)
				ST_CMD:
				begin
					// Bytes with the enable bit high are dropped
					sel_q <= next_sel;
					len_q <= bra_xfer_len(next_sel, mode_q[MODE_WL_BIT]);
					if (cmd.wen_n || next_sel == SEL_COMMAND)
						len_q <= LEN_CMD;
					else
						unique case ({cmd.access_dir_hi, cmd.access_dir_lo})
							DIR_WRITE: state_q <= ST_WR;
							DIR_READ: state_q <= ST_RD;
							DIR_CONT_START:
							begin
								state_q <= ST_RD;
								cont_q <= 1'b1;
							end
							DIR_CONT_STOP:
							begin
								cont_q <= 1'b0;
								len_q <= LEN_CMD;
							end
						endcase
				end
				ST_WR:
				begin
					state_q <= ST_CMD;
					len_q <= LEN_CMD;
				end
				ST_RD:
				begin
					// Stop byte sent during a continuous word ends it
					if (!cont_q || !load)
					begin
						state_q <= ST_CMD;
						len_q <= LEN_CMD;
						cont_q <= 1'b0;
					end
				end
				default:
				begin
					state_q <= ST_CMD;
					len_q <= LEN_CMD;
				end
			endcase
		end
		else if (rise)
			cnt_q <= cnt_q + 5'h01;
	end

	// The first bit already sits on dout after a load, so skip one fall
	always_ff @(posedge clk)
	begin
		if (!rstn)
			skip_q <= 1'b0;
		else if (load)
			skip_q <= 1'b1;
		else if (fall)
			skip_q <= 1'b0;
	end

	// Read path serialiser; its output bit is a flop
	bra_shift #(.W(24)) u_shift (
		.clk(clk),
		.rstn(rstn),
		.load(load),
		.load_val(rd_word),
		.shift(fall && !skip_q && !load),
		.sout(dout)
	);

	// Mode register, written only through the serial port
	always_ff @(posedge clk)
	begin
		if (!rstn)
			mode_q <= MODE_RESET;
		else if (done && state_q == ST_WR && sel_q == SEL_MODE)
			mode_q <= word_in[15:0];
	end

	assign clock_out_disable = mode_q[MODE_CLOCK_OUT_DISABLE_BIT];

	// Newest result always replaces the old one
	always_ff @(posedge clk)
	begin
		if (!rstn)
			result_q <= RESULT_RESET;
		else if (adc.valid)
			result_q <= adc.data;
	end

	// Unread flag: a new result wins over the clearing read
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pending_q <= 1'b0;
		else if (adc.valid)
			pending_q <= 1'b1;
		else if (done && state_q == ST_RD && sel_q == SEL_DATA)
			pending_q <= 1'b0;
	end

	// Status flags copied from the conversion side
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			settled_q <= STATUS_RESET_HI[2];
			standby_q <= STATUS_RESET_HI[1];
			refmiss_q <= STATUS_RESET_HI[0];
		end
		else
		begin
			settled_q <= adc.step_settled_flag;
			standby_q <= adc.standby_flag;
			refmiss_q <= adc.reference_missing_flag;
		end
	end

	// Checks
	property p_status_reset;
		@(posedge clk) !rstn |=> status_byte[7:4] == STATUS_RESET_HI;
	endproperty
	a_status_reset: assert property (p_status_reset)
		else $error("status upper nibble wrong after reset");

	property p_mode_reset;
		@(posedge clk) !rstn |=> mode_q == MODE_RESET;
	endproperty
	a_mode_reset: assert property (p_mode_reset)
		else $error("mode register wrong after reset");

	property p_result_reset;
		@(posedge clk) !rstn ##1 (rstn && !$past(adc.valid))
			|-> result_q == RESULT_RESET;
	endproperty
	a_result_reset: assert property (p_result_reset)
		else $error("result register not zero after reset");

	property p_wait_cmd;
		@(posedge clk) !rstn |=> state_q == ST_CMD && len_q == LEN_CMD;
	endproperty
	a_wait_cmd: assert property (p_wait_cmd)
		else $error("not waiting for command after reset");

	property p_cmd_read;
		@(posedge clk) disable iff (!rstn)
		(done && state_q == ST_CMD && !cmd.wen_n && next_sel != SEL_COMMAND
		&& {cmd.access_dir_hi, cmd.access_dir_lo} == DIR_READ)
		|=> state_q == ST_RD && dout == $past(rd_word[23]);
	endproperty
	a_cmd_read: assert property (p_cmd_read)
		else $error("read command did not start a read");

	property p_return;
		@(posedge clk) disable iff (!rstn)
		(done && state_q != ST_CMD && !cont_q) |=> state_q == ST_CMD;
	endproperty
	a_return: assert property (p_return)
		else $error("did not return to command wait");

	property p_short_len;
		@(posedge clk) disable iff (!rstn)
		(done && state_q == ST_CMD && go_read && next_sel == SEL_DATA
		&& !mode_q[MODE_WL_BIT]) |=> len_q == LEN_HALF;
	endproperty
	a_short_len: assert property (p_short_len)
		else $error("short result length not used");

	property p_cmd_count;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_CMD |-> cnt_q < LEN_CMD;
	endproperty
	a_cmd_count: assert property (p_cmd_count)
		else $error("command byte longer than eight bits");

	property p_clock_out_disable;
		@(posedge clk) disable iff (!rstn)
		(done && state_q == ST_WR && sel_q == SEL_MODE)
		|=> clock_out_disable == $past(word_in[MODE_CLOCK_OUT_DISABLE_BIT]);
	endproperty
	a_clock_out_disable: assert property (p_clock_out_disable)
		else $error("clock output disable not taken from mode write");

	property p_data_clear;
		@(posedge clk) disable iff (!rstn)
		(done && state_q == ST_RD && sel_q == SEL_DATA && !adc.valid)
		|=> !pending_q;
	endproperty
	a_data_clear: assert property (p_data_clear)
		else $error("result read did not clear ready");

	c_cont: cover property (@(posedge clk) disable iff (!rstn)
		$rose(cont_q));
	c_mode_wr: cover property (@(posedge clk) disable iff (!rstn)
		done && state_q == ST_WR && sel_q == SEL_MODE);
	c_data_rd: cover property (@(posedge clk) disable iff (!rstn)
		done && state_q == ST_RD && sel_q == SEL_DATA);

endmodule

/* bra_host.sv */
// Host model on the serial port of the register front end.
// Assumes the device samples din on sclk rise and is clocked by clk.
`timescale 1ns/100ps
module bra_host
	import bra_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic dout, // Read data from device
	output logic sclk, // Serial clock, idles high
	output logic din, // Write data to device
	output logic cs_n // Chip select, active low
);
	localparam int PH = 6; // Clocks per sclk phase; margin over three

	// Idle lines at time zero
	initial
	begin
		sclk = 1'b1;
		din = 1'b1;
		cs_n = 1'b1;
	end

	// Select or release; a released data line toggles, never holds
	task automatic sel(input logic on);
		@(posedge clk);
		cs_n <= !on;
		if (!on)
			din <= !din;
		repeat (PH) @(posedge clk);
	endtask

	// Shift n bits MSB first; read bit sampled late in the low phase
	task automatic shift(input int n, input logic [23:0] w,
		output logic [23:0] r);
		r = 24'h000000;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk);
			sclk <= 1'b0;
			din <= w[i];
			repeat (PH - 1) @(posedge clk);
			@(negedge clk);
			r[i] = dout;
			@(posedge clk);
			sclk <= 1'b1;
			repeat (PH - 1) @(posedge clk);
		end
	endtask
endmodule

/* tb.sv */
// Self-checking bench for the register front end.
// Assumes the host model and the conversion report share clk.
`timescale 1ns/100ps
module tb
	import bra_pkg::*;
;
	logic clk, rstn, sclk, din, cs_n, dout, clock_out_disable;
	logic [15:0] mode_q; // Mode register as seen by analog side
	bra_adc_s adc; // Conversion report into the device
	int error_cnt, cmp_count;
	logic [23:0] rd; // Last word read back

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	bra_regs i_bra_regs (.clk(clk), .rstn(rstn), .sclk(sclk), .din(din),
		.cs_n(cs_n), .adc(adc), .dout(dout), .mode_q(mode_q),
		.clock_out_disable(clock_out_disable));
	bra_host i_bra_host (.clk(clk), .dout(dout), .sclk(sclk), .din(din),
		.cs_n(cs_n));

	// Compare and count
	task automatic check(input string nm, input logic [23:0] seen,
		input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Command byte then one transfer inside one select
	task automatic access(input logic [7:0] cmd, input int n,
		input logic [23:0] w, output logic [23:0] r);
		i_bra_host.sel(1'b1);
		i_bra_host.shift(8, {16'h0000, cmd}, r);
		i_bra_host.shift(n, w, r);
		i_bra_host.sel(1'b0);
	endtask

	// One-cycle result pulse
	task automatic result(input logic [23:0] val);
		@(posedge clk);
		adc.valid <= 1'b1;
		adc.data <= val;
		@(posedge clk);
		adc.valid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Main sequence
	initial
	begin
		error_cnt = 0;
		cmp_count = 0;
		rstn = 1'b0;
		adc = '0;
		adc.step_settled_flag = 1'b1;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		// Reset values
		check("mode_q", {8'h00, mode_q}, {8'h00, MODE_RESET});
		check("clock_out_disable", {23'h0, clock_out_disable}, 24'h0);
		access(8'h13, 16, 24'h0, rd);
		check("mode", rd, {8'h00, MODE_RESET});
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, {16'h0, STATUS_RESET_HI, 4'h0});
		access(8'h12, 24, 24'h0, rd);
		check("result", rd, RESULT_RESET);
		$display("test reset done");
		// Aborted word, ignored command, write to read-only status
		i_bra_host.sel(1'b1);
		i_bra_host.shift(5, 24'h00001F, rd);
		i_bra_host.sel(1'b0);
		i_bra_host.sel(1'b1);
		i_bra_host.shift(8, 24'h000093, rd);
		i_bra_host.shift(8, 24'h000013, rd);
		i_bra_host.shift(16, 24'h0, rd);
		i_bra_host.sel(1'b0);
		check("mode", rd, {8'h00, MODE_RESET});
		access(8'h01, 8, 24'h00003F, rd);
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, 24'h0000C0);
		$display("test refuse done");
		// Mode write, flags and echo
		access(8'h03, 16, 24'h00A0B8, rd);
		check("mode_q", {8'h00, mode_q}, 24'h00A0B8);
		check("clock_out_disable", {23'h0, clock_out_disable}, 24'h1);
		@(posedge clk);
		adc.step_settled_flag <= 1'b0;
		adc.standby_flag <= 1'b1;
		adc.reference_missing_flag <= 1'b1;
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, 24'h0000BA);
		$display("test mode done");
		// Short result and ready flag
		result(24'hABCDEF);
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, 24'h00003A);
		access(8'h12, 16, 24'h0, rd);
		check("result", rd, 24'h00ABCD);
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, 24'h0000BA);
		$display("test short done");
		// Long result, then continuous read and its stop
		access(8'h03, 16, {8'h00, MODE_RESET}, rd);
		result(24'h123456);
		access(8'h12, 24, 24'h0, rd);
		check("result", rd, 24'h123456);
		result(24'h654321);
		i_bra_host.sel(1'b1);
		i_bra_host.shift(8, 24'h000022, rd);
		i_bra_host.shift(24, 24'h0, rd);
		check("cont1", rd, 24'h654321);
		i_bra_host.shift(24, 24'h000032, rd);
		check("cont2", rd, 24'h654321);
		i_bra_host.shift(8, 24'h000013, rd);
		i_bra_host.shift(16, 24'h0, rd);
		i_bra_host.sel(1'b0);
		check("mode", rd, {8'h00, MODE_RESET});
		$display("test continuous done");
		// Unmodelled reads, stop code as a command, resumed stream
		access(8'h03, 16, 24'h0001B8, rd);
		check("mode_q", {8'h00, mode_q}, 24'h0001B8);
		check("clock_out_disable", {23'h0, clock_out_disable}, 24'h1);
		i_bra_host.sel(1'b1);
		i_bra_host.shift(8, 24'h000015, rd);
		i_bra_host.shift(8, 24'h0, rd);
		check("dac", rd, 24'h0);
		i_bra_host.shift(8, 24'h000016, rd);
		i_bra_host.shift(24, 24'h0, rd);
		check("sel6", rd, 24'h0);
		i_bra_host.shift(8, 24'h000032, rd);
		i_bra_host.shift(8, 24'h000013, rd);
		i_bra_host.shift(16, 24'h0, rd);
		check("mode", rd, 24'h0001B8);
		i_bra_host.shift(8, 24'h000022, rd);
		i_bra_host.shift(24, 24'h0, rd);
		check("cont3", rd, 24'h654321);
		i_bra_host.sel(1'b0);
		i_bra_host.sel(1'b1);
		i_bra_host.shift(24, 24'h0, rd);
		check("cont4", rd, 24'h654321);
		i_bra_host.sel(1'b0);
		$display("test stream done");
		// Reset in mid-run with a stream still armed and mode changed
		@(posedge clk);
		adc.step_settled_flag <= 1'b1;
		adc.standby_flag <= 1'b0;
		adc.reference_missing_flag <= 1'b0;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		check("mode_q", {8'h00, mode_q}, {8'h00, MODE_RESET});
		check("clock_out_disable", {23'h0, clock_out_disable}, 24'h0);
		access(8'h11, 8, 24'h0, rd);
		check("status", rd, 24'h0000C0);
		access(8'h12, 24, 24'h0, rd);
		check("result", rd, RESULT_RESET);
		$display("test rerun done");
		conclude();
	end
endmodule
